// >>> hw/sal_map.svh
// Purpose: Constants for the supervisor alert logic: offsets, fields, timing counts.
// Assumes: 100 MHz ref_clk_i.
// Notes:   Included by the design, monitor and bench files.
`ifndef SAL_MAP_SVH
`define SAL_MAP_SVH

`define SAL_CLK_MHZ          100
`define SAL_CNT_W            20

// Register byte offsets
`define SAL_OFF_CTRL         5'h00
`define SAL_OFF_TIMEOUT      5'h04
`define SAL_OFF_STATUS       5'h08
`define SAL_OFF_IRQ_STAT     5'h0C
`define SAL_OFF_IRQ_MASK     5'h10

// Fields and reset values
`define SAL_CTRL_TEMP_EN     0
`define SAL_CTRL_RST         32'h0000_0001
`define SAL_IRQ_W            4
`define SAL_ST_PIN_LSB       4
`define SAL_ST_SUPPLY_OK     8
`define SAL_ST_OUT_PWR       9

// Alert channel indices
`define SAL_CH_UV            0
`define SAL_CH_OV            1
`define SAL_CH_T1            2
`define SAL_CH_T2            3

// Timing
`define SAL_FILT_US          20
`define SAL_FILT_CYC         ((`SAL_FILT_US * `SAL_CLK_MHZ) > 1 ? \
                              (`SAL_FILT_US * `SAL_CLK_MHZ) : 1)
`define SAL_TMR_OPEN_US      500
`define SAL_TMR_OPEN_CYC     (`SAL_TMR_OPEN_US * `SAL_CLK_MHZ)
`define SAL_TMR_CAP_RST      20'h186A0
`define SAL_QUAL_COUNT       3'h5

`endif

// >>> hw/sal_pkg.sv
// Purpose: Types shared by the supervisor alert logic.
// Assumes: Three-state pins are already resolved to a code.
// Notes:   Constants live in sal_map.svh.
package sal_pkg;
    typedef enum logic [1:0] {
        SAL_PIN_GND  = 2'h0,
        SAL_PIN_OPEN = 2'h1,
        SAL_PIN_VCC  = 2'h2
    } sal_tri_t;

    typedef enum logic [1:0] {
        SAL_TMR_RELEASED = 2'h0,
        SAL_TMR_ASSERTED = 2'h1,
        SAL_TMR_TIMING   = 2'h2
    } sal_tmr_state_t;
endpackage

// >>> hw/sal_alert_timer.sv
// Purpose: One alert output: holds the alert for a restartable timeout after the fault.
// Assumes: fault_i is already qualified or filtered.
// Notes:   clear_i releases at once, without timeout.
`timescale 1ns/1ps
`default_nettype none
`include "sal_map.svh"
module sal_alert_timer #(
    parameter logic RESET_ASSERTED = 1'b0
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  fault_i,
    input  wire logic                  clear_i,
    input  wire logic                  skip_i,
    input  wire logic [`SAL_CNT_W-1:0] load_i,
    output logic                       alert_o
);
    import sal_pkg::*;

    sal_tmr_state_t        state_r;
    logic [`SAL_CNT_W-1:0] cnt_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_r <= RESET_ASSERTED ? SAL_TMR_ASSERTED : SAL_TMR_RELEASED;
            cnt_r   <= '0;
        end else if (clear_i) begin
            state_r <= SAL_TMR_RELEASED;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                SAL_TMR_RELEASED: begin
                    if (fault_i) begin
                        state_r <= SAL_TMR_ASSERTED;
                    end
                end
                SAL_TMR_ASSERTED: begin
                    if (!fault_i) begin
                        if (skip_i) begin
                            state_r <= SAL_TMR_RELEASED;
                        end else begin
                            state_r <= SAL_TMR_TIMING;
                            cnt_r   <= load_i;
                        end
                    end
                end
                SAL_TMR_TIMING: begin
                    if (fault_i) begin
                        state_r <= SAL_TMR_ASSERTED;
                        cnt_r   <= '0;
                    end else if (cnt_r <= `SAL_CNT_W'(1)) begin
                        state_r <= SAL_TMR_RELEASED;
                    end else begin
                        cnt_r <= cnt_r - `SAL_CNT_W'(1);
                    end
                end
                default: begin
                    state_r <= SAL_TMR_ASSERTED;
                end
            endcase
        end
    end

    assign alert_o = (state_r != SAL_TMR_RELEASED);
endmodule // sal_alert_timer
`default_nettype wire

// >>> hw/sal_alert_logic.sv
// Purpose: Alert and timeout logic of a voltage and temperature supervisor.
// Assumes: All inputs synchronous to ref_clk_i; temp_update_i pulses once per conversion.
// Notes:   Alerts are open-drain enables; the pin out value is always low.
`timescale 1ns/1ps
`default_nettype none
`include "sal_map.svh"
// Function
// - Either high-side tap below trip drives the low-supply alert low.
// - Either low-side tap above trip drives the excess-voltage alert low.
// - Voltage comparisons are integrated; only long, large disturbances raise an alert.
// - Temperature alert asserts after five consecutive conversions past its threshold.
// - Release follows one update past threshold plus hysteresis, then the timeout.
// - Every alert is held for the timeout after its fault clears; lockout releases all but the low-supply alert at once.
// - Low-supply timer starts when all high-side taps recover; releases if still valid.
// - A high-side fault during timing clears the timer; restart on full recovery.
// - At power-up the low-supply alert is held low, others released.
// - Timer starts once supply and both high-side taps are valid.
// - Supply below lockout asserts low-supply alert and clears excess-voltage alert.
// - With two overtemp limits both temperature alerts act independently.
// - Overtemp output timer starts once below threshold minus hysteresis.
// - Polarity high: first undertemp, second overtemp; grounded: both undertemp.
// - Sensor select open: internal reading to first threshold, external to second.
// - Timeout pin tied high skips the timeout entirely.
module sal_alert_logic #(
    parameter logic [`SAL_CNT_W-1:0] TMR_OPEN_CYC = `SAL_CNT_W'(`SAL_TMR_OPEN_CYC)
) (
    input  wire logic            ref_clk_i,
    input  wire logic            rstn_i,
    input  wire logic [4:0]      avs_address_i,
    input  wire logic            avs_read_i,
    input  wire logic            avs_write_i,
    input  wire logic [31:0]     avs_writedata_i,
    input  wire logic [3:0]      avs_byteenable_i,
    output logic [31:0]          avs_readdata_o,
    output logic                 avs_waitrequest_o,
    output logic                 irq_o,
    input  wire logic            supply_outputs_ok_i,
    input  wire logic            supply_lockout_n_i,
    input  wire logic            high_side_tap_one_low_i,
    input  wire logic            high_side_tap_two_low_i,
    input  wire logic            low_side_tap_one_high_i,
    input  wire logic            low_side_tap_two_high_i,
    input  wire logic            temp_update_i,
    input  wire logic            temp_sensor_ext_i,
    input  wire logic            temp_above_one_i,
    input  wire logic            temp_above_one_hys_i,
    input  wire logic            temp_below_one_hys_i,
    input  wire logic            temp_above_two_i,
    input  wire logic            temp_above_two_hys_i,
    input  wire logic            temp_below_two_hys_i,
    input  wire sal_pkg::sal_tri_t sensor_select_pin_i,
    input  wire sal_pkg::sal_tri_t polarity_select_pin_i,
    input  wire sal_pkg::sal_tri_t timeout_cap_pin_i,
    input  wire logic            low_supply_alert_n_i,
    output logic                 low_supply_alert_n_o,
    output logic                 low_supply_alert_n_oe_o,
    input  wire logic            excess_voltage_alert_n_i,
    output logic                 excess_voltage_alert_n_o,
    output logic                 excess_voltage_alert_n_oe_o,
    input  wire logic            temp_alert_one_n_i,
    output logic                 temp_alert_one_n_o,
    output logic                 temp_alert_one_n_oe_o,
    input  wire logic            temp_alert_two_n_i,
    output logic                 temp_alert_two_n_o,
    output logic                 temp_alert_two_n_oe_o
);
    import sal_pkg::*;

    localparam int FILT_W = $clog2(`SAL_FILT_CYC + 1);
    localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(`SAL_FILT_CYC);

    // Byte-lane merge for register writes
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ---------------- Voltage glitch filters ----------------
    logic [3:0]        raw_v;
    logic [3:0]        filt_r;
    logic [FILT_W-1:0] integ_r [4];

    assign raw_v = {low_side_tap_two_high_i, low_side_tap_one_high_i,
                    high_side_tap_two_low_i, high_side_tap_one_low_i};

    // Integrating up/down counter with saturation; a short glitch decays before it trips
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (!rstn_i) begin
                integ_r[i] <= '0;
                filt_r[i]  <= 1'b0;
            end else begin
                if (raw_v[i] && integ_r[i] != FILT_MAX) begin
                    integ_r[i] <= integ_r[i] + FILT_W'(1);
                end else if (!raw_v[i] && integ_r[i] != '0) begin
                    integ_r[i] <= integ_r[i] - FILT_W'(1);
                end
                if (integ_r[i] == FILT_MAX) begin
                    filt_r[i] <= 1'b1;
                end else if (integ_r[i] == '0) begin
                    filt_r[i] <= 1'b0;
                end
            end
        end
    end

    logic lockout;
    logic uv_fault;
    logic ov_fault;

    assign lockout  = !supply_lockout_n_i || !supply_outputs_ok_i;
    assign uv_fault = lockout || filt_r[0] || filt_r[1];
    assign ov_fault = filt_r[2] || filt_r[3];

    // ---------------- Temperature qualification ----------------
    logic [1:0] use_ch;
    logic [1:0] ut_mode;
    logic [1:0] t_fault;
    logic [1:0] t_clear;
    logic [2:0] qual_r [2];
    logic [1:0] t_active_r;
    logic       temp_en;

    // Alternating sensors: each threshold sees only its own sensor
    assign use_ch[0] = (sensor_select_pin_i != SAL_PIN_OPEN) || !temp_sensor_ext_i;
    assign use_ch[1] = (sensor_select_pin_i != SAL_PIN_OPEN) || temp_sensor_ext_i;

    assign ut_mode[0] = (polarity_select_pin_i != SAL_PIN_OPEN);
    assign ut_mode[1] = (polarity_select_pin_i == SAL_PIN_GND);

    assign t_fault[0] = ut_mode[0] ? !temp_above_one_i : temp_above_one_i;
    assign t_fault[1] = ut_mode[1] ? !temp_above_two_i : temp_above_two_i;
    assign t_clear[0] = ut_mode[0] ? temp_above_one_hys_i : temp_below_one_hys_i;
    assign t_clear[1] = ut_mode[1] ? temp_above_two_hys_i : temp_below_two_hys_i;

    always_ff @(posedge ref_clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (!rstn_i || lockout || !temp_en) begin
                qual_r[c]     <= '0;
                t_active_r[c] <= 1'b0;
            end else if (temp_update_i && use_ch[c]) begin
                if (!t_fault[c]) begin
                    qual_r[c] <= '0;
                end else if (qual_r[c] != `SAL_QUAL_COUNT) begin
                    qual_r[c] <= qual_r[c] + 3'h1;
                end
                if (t_fault[c] && qual_r[c] == `SAL_QUAL_COUNT - 3'h1) begin
                    t_active_r[c] <= 1'b1;
                end else if (t_clear[c]) begin
                    t_active_r[c] <= 1'b0;
                end
            end
        end
    end

    // ---------------- Timeout and alert channels ----------------
    logic [31:0]           ctrl_r;
    logic [`SAL_CNT_W-1:0] tmr_cap_r;
    logic [`SAL_CNT_W-1:0] tmr_load;
    logic                  tmr_skip;
    logic [3:0]            alert;
    logic [3:0]            ch_fault;
    logic [3:0]            ch_clear;

    assign temp_en  = ctrl_r[`SAL_CTRL_TEMP_EN];
    assign tmr_skip = (timeout_cap_pin_i == SAL_PIN_VCC);
    assign tmr_load = (timeout_cap_pin_i == SAL_PIN_OPEN) ? TMR_OPEN_CYC : tmr_cap_r;

    assign ch_fault = {t_active_r[1], t_active_r[0], ov_fault, uv_fault};
    // Lockout releases the others immediately rather than timing them out
    assign ch_clear = {lockout, lockout, lockout, 1'b0};

    for (genvar g = 0; g < 4; g++) begin : g_ch
        sal_alert_timer #(
            .RESET_ASSERTED (g == `SAL_CH_UV)
        ) u_tmr (
            .ref_clk_i (ref_clk_i),
            .rstn_i    (rstn_i),
            .fault_i   (ch_fault[g]),
            .clear_i   (ch_clear[g]),
            .skip_i    (tmr_skip),
            .load_i    (tmr_load),
            .alert_o   (alert[g])
        );
    end

    // Below the output-operable supply nothing can be driven
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            low_supply_alert_n_oe_o     <= 1'b0;
            excess_voltage_alert_n_oe_o <= 1'b0;
            temp_alert_one_n_oe_o       <= 1'b0;
            temp_alert_two_n_oe_o       <= 1'b0;
        end else begin
            low_supply_alert_n_oe_o     <= alert[`SAL_CH_UV] && supply_outputs_ok_i;
            excess_voltage_alert_n_oe_o <= alert[`SAL_CH_OV] && supply_outputs_ok_i;
            temp_alert_one_n_oe_o       <= alert[`SAL_CH_T1] && supply_outputs_ok_i;
            temp_alert_two_n_oe_o       <= alert[`SAL_CH_T2] && supply_outputs_ok_i;
        end
    end

    assign low_supply_alert_n_o     = 1'b0;
    assign excess_voltage_alert_n_o = 1'b0;
    assign temp_alert_one_n_o       = 1'b0;
    assign temp_alert_two_n_o       = 1'b0;

    // ---------------- Avalon-MM slave ----------------
    logic        ack_r;
    logic        req;
    logic        wr_acc;
    logic [3:0]  alert_q_r;
    logic [3:0]  irq_stat_r;
    logic [3:0]  irq_mask_r;
    logic [3:0]  rise;
    logic [31:0] rd_mux;
    logic [31:0] w1c;

    assign req               = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = req && !ack_r;
    assign wr_acc            = avs_write_i && ack_r;
    assign w1c               = be_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ctrl_r    <= `SAL_CTRL_RST;
            tmr_cap_r <= `SAL_TMR_CAP_RST;
        end else if (wr_acc) begin
            if (avs_address_i == `SAL_OFF_CTRL) begin
                ctrl_r <= be_merge(ctrl_r, avs_writedata_i, avs_byteenable_i) & `SAL_CTRL_RST;
            end
            if (avs_address_i == `SAL_OFF_TIMEOUT) begin
                tmr_cap_r <= `SAL_CNT_W'(be_merge(32'(tmr_cap_r), avs_writedata_i,
                                                  avs_byteenable_i));
            end
        end
    end

    // Alert assertion edges are the interrupt events; a set in the clear cycle wins
    assign rise = alert & ~alert_q_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            alert_q_r  <= '0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            alert_q_r <= alert;
            if (wr_acc && avs_address_i == `SAL_OFF_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~w1c[`SAL_IRQ_W-1:0]) | rise;
            end else begin
                irq_stat_r <= irq_stat_r | rise;
            end
            if (wr_acc && avs_address_i == `SAL_OFF_IRQ_MASK) begin
                irq_mask_r <= be_merge(32'(irq_mask_r), avs_writedata_i,
                                       avs_byteenable_i) [`SAL_IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            `SAL_OFF_CTRL:     rd_mux = ctrl_r;
            `SAL_OFF_TIMEOUT:  rd_mux = 32'(tmr_cap_r);
            `SAL_OFF_STATUS: begin
                rd_mux[3:0]                                = alert;
                rd_mux[`SAL_ST_PIN_LSB +: 4]               = {temp_alert_two_n_i,
                                                             temp_alert_one_n_i,
                                                             excess_voltage_alert_n_i,
                                                             low_supply_alert_n_i};
                rd_mux[`SAL_ST_SUPPLY_OK]                  = supply_lockout_n_i;
                rd_mux[`SAL_ST_OUT_PWR]                    = supply_outputs_ok_i;
            end
            `SAL_OFF_IRQ_STAT: rd_mux = 32'(irq_stat_r);
            `SAL_OFF_IRQ_MASK: rd_mux = 32'(irq_mask_r);
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_r) begin
            avs_readdata_o <= rd_mux;
        end
    end
endmodule // sal_alert_logic
`default_nettype wire

// >>> sim/sal_alert_logic_monitor.sv
// Purpose: Port-level checker for the supervisor alert logic.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Enables lag alerts by one edge.
`timescale 1ns/1ps
`default_nettype none
`include "sal_map.svh"
module sal_alert_logic_monitor #(
    parameter logic [`SAL_CNT_W-1:0] TMR_OPEN_CYC = `SAL_CNT_W'(20)
) (
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic              avs_waitrequest_o,
    input wire logic              supply_outputs_ok_i,
    input wire logic              supply_lockout_n_i,
    input wire logic              high_side_tap_one_low_i,
    input wire logic              high_side_tap_two_low_i,
    input wire logic              temp_update_i,
    input wire logic              temp_above_one_i,
    input wire sal_pkg::sal_tri_t sensor_select_pin_i,
    input wire sal_pkg::sal_tri_t polarity_select_pin_i,
    input wire sal_pkg::sal_tri_t timeout_cap_pin_i,
    input wire logic              low_supply_alert_n_o,
    input wire logic              low_supply_alert_n_oe_o,
    input wire logic              excess_voltage_alert_n_o,
    input wire logic              excess_voltage_alert_n_oe_o,
    input wire logic              temp_alert_one_n_o,
    input wire logic              temp_alert_one_n_oe_o,
    input wire logic              temp_alert_two_n_o,
    input wire logic              temp_alert_two_n_oe_o
);
    import sal_pkg::*;
    logic [2:0] run_one_r;
    logic       taps_ok;
    assign taps_ok = !high_side_tap_one_low_i && !high_side_tap_two_low_i;
    // Hot-conversion run of channel one
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || !supply_lockout_n_i || !supply_outputs_ok_i) begin
            run_one_r <= 3'h0;
        end else if (temp_update_i) begin
            run_one_r <= !temp_above_one_i ? 3'h0 : run_one_r + {2'h0, run_one_r != 3'h7};
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_pins_low_only: assert property (
        (low_supply_alert_n_o | excess_voltage_alert_n_o | temp_alert_one_n_o
         | temp_alert_two_n_o) == 1'b0) else $error("alert pin driven high");
    a_one_wait: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    a_uv_lockout: assert property (
        supply_outputs_ok_i && !supply_lockout_n_i ##1 supply_outputs_ok_i
        |=> low_supply_alert_n_oe_o) else $error("lockout did not pull low supply alert");
    a_lockout_clears: assert property (
        !supply_lockout_n_i |-> ##2 !excess_voltage_alert_n_oe_o && !temp_alert_one_n_oe_o
        && !temp_alert_two_n_oe_o) else $error("lockout left an alert driven");
    a_unpowered_quiet: assert property (
        !supply_outputs_ok_i ##1 !supply_outputs_ok_i |=> {low_supply_alert_n_oe_o,
        excess_voltage_alert_n_oe_o, temp_alert_one_n_oe_o, temp_alert_two_n_oe_o} == 4'h0)
        else $error("alert driven without output supply");
    a_temp_five: assert property (
        $rose(temp_alert_one_n_oe_o) && sensor_select_pin_i == SAL_PIN_VCC
        && polarity_select_pin_i == SAL_PIN_OPEN |-> $past(run_one_r) == 3'h5)
        else $error("temperature alert not on fifth hot conversion");
    a_uv_hold: assert property (
        $rose(supply_lockout_n_i) && supply_outputs_ok_i && taps_ok && TMR_OPEN_CYC > 10
        && timeout_cap_pin_i == SAL_PIN_OPEN |-> ##2 low_supply_alert_n_oe_o [*8])
        else $error("low supply alert released before timeout");
    a_skip_release: assert property (
        $rose(supply_lockout_n_i) && supply_outputs_ok_i && taps_ok
        && timeout_cap_pin_i == SAL_PIN_VCC |-> ##[1:8] !low_supply_alert_n_oe_o)
        else $error("skipped timeout still delayed release");
endmodule // sal_alert_logic_monitor
bind sal_alert_logic sal_alert_logic_monitor #(.TMR_OPEN_CYC(TMR_OPEN_CYC)) i_mon (.*);
`default_nettype wire

// >>> sim/sal_board_model.sv
// Purpose: Host board around the alert pins: pull-ups and strap pins.
// Assumes: Alert pins are open-drain with a weak pull-up.
// Notes:   strap_i 0 normal, 1 sensors alternate, 2 polarity high, 3 polarity low.
`timescale 1ns/1ps
`default_nettype none
module sal_board_model (
    input  wire logic [1:0]      strap_i,
    input  wire logic [3:0]      oe_i,
    output logic [3:0]           pin_o,
    output var sal_pkg::sal_tri_t sensor_sel_o,
    output var sal_pkg::sal_tri_t polarity_sel_o
);
    import sal_pkg::*;
    // Released pin floats up
    assign pin_o = ~oe_i;
    assign sensor_sel_o = (strap_i == 2'h1) ? SAL_PIN_OPEN : SAL_PIN_VCC;
    always_comb begin
        case (strap_i)
            2'h2: polarity_sel_o = SAL_PIN_VCC;
            2'h3: polarity_sel_o = SAL_PIN_GND;
            default: polarity_sel_o = SAL_PIN_OPEN;
        endcase
    end
endmodule // sal_board_model
`default_nettype wire

// >>> sim/sal_alert_logic_tb.sv
// Purpose: Bench for the supervisor alert logic.
// Assumes: Open-pin timeout shortened to 20 cycles; filter stays 2000 cycles.
// Notes:   Pin levels are read back through the board pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "sal_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module sal_alert_logic_tb;
    import sal_pkg::*;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic avs_waitrequest_o, irq_o, supply_outputs_ok_i = 1'b1, supply_lockout_n_i = 1'b0;
    logic high_side_tap_one_low_i = 1'b0, high_side_tap_two_low_i = 1'b0;
    logic low_side_tap_one_high_i = 1'b0, low_side_tap_two_high_i = 1'b0;
    logic temp_update_i = 1'b0, temp_sensor_ext_i = 1'b0, temp_above_one_i = 1'b0;
    logic temp_above_one_hys_i = 1'b0, temp_below_one_hys_i = 1'b1, temp_above_two_i = 1'b0;
    logic temp_above_two_hys_i = 1'b0, temp_below_two_hys_i = 1'b1;
    logic [3:0] n_o;
    logic [1:0] strap = 2'h0;
    wire logic [3:0] pin, oe;
    sal_tri_t timeout_cap_pin_i = SAL_PIN_OPEN;
    sal_tri_t sensor_select_pin_i, polarity_select_pin_i;
    int miscompares = 0, checked = 0, n;
    sal_board_model i_board (.strap_i(strap), .oe_i(oe), .pin_o(pin),
        .sensor_sel_o(sensor_select_pin_i), .polarity_sel_o(polarity_select_pin_i));
    sal_alert_logic #(.TMR_OPEN_CYC(20'h14)) i_dut (.*, .low_supply_alert_n_i(pin[0]),
        .low_supply_alert_n_o(n_o[0]), .low_supply_alert_n_oe_o(oe[0]),
        .excess_voltage_alert_n_i(pin[1]), .excess_voltage_alert_n_o(n_o[1]),
        .excess_voltage_alert_n_oe_o(oe[1]), .temp_alert_one_n_i(pin[2]),
        .temp_alert_one_n_o(n_o[2]), .temp_alert_one_n_oe_o(oe[2]),
        .temp_alert_two_n_i(pin[3]), .temp_alert_two_n_o(n_o[3]), .temp_alert_two_n_oe_o(oe[3]));
    task automatic stop_test(input logic hung);
        if (hung) miscompares++;
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask
    // Held until waitrequest low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk_i);
            if (!avs_waitrequest_o) break;
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (i >= 20) stop_test(1'b1);
        @(posedge ref_clk_i);
    endtask
    // f = {ext, below2, above2_hys, above2, below1, above1_hys, above1}
    task automatic upd(input logic [6:0] f, input int k);
        repeat (k) begin
            {temp_sensor_ext_i, temp_below_two_hys_i, temp_above_two_hys_i, temp_above_two_i,
             temp_below_one_hys_i, temp_above_one_hys_i, temp_above_one_i} <= f;
            temp_update_i <= 1'b1;
            @(posedge ref_clk_i);
            temp_update_i <= 1'b0;
            tick(3);
        end
    endtask
    task automatic wait_pin(input int k, input int lim);
        n = 0;
        while (pin[k] !== 1'b1 && n < lim) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= lim) stop_test(1'b1);
    endtask
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        tick(8);
        rstn_i <= 1'b1;
        tick(4);
        `CHK(pin, 4'hE)
        bus(1'b0, `SAL_OFF_TIMEOUT, 32'h0);
        `CHK(q, 32'h0001_86A0)
        bus(1'b0, `SAL_OFF_CTRL, 32'h0);
        `CHK(q, `SAL_CTRL_RST)
        bus(1'b0, 5'h14, 32'h0);
        `CHK(q, 32'h0)
        supply_lockout_n_i <= 1'b1;
        wait_pin(0, 100);
        `CHK(n >= 20, 1'b1)
        high_side_tap_one_low_i <= 1'b1;
        tick(100);
        high_side_tap_one_low_i <= 1'b0;
        tick(300);
        `CHK(pin[0], 1'b1)
        timeout_cap_pin_i <= SAL_PIN_GND;
        bus(1'b1, `SAL_OFF_TIMEOUT, 32'h0000_0BB8);
        high_side_tap_two_low_i <= 1'b1;
        tick(1990);
        `CHK(pin[0], 1'b1)
        tick(110);
        `CHK(pin[0], 1'b0)
        high_side_tap_two_low_i <= 1'b0;
        tick(3000);
        high_side_tap_one_low_i <= 1'b1;
        tick(2100);
        `CHK(pin[0], 1'b0)
        high_side_tap_one_low_i <= 1'b0;
        wait_pin(0, 6000);
        `CHK(n >= 4990, 1'b1)
        timeout_cap_pin_i <= SAL_PIN_OPEN;
        bus(1'b1, `SAL_OFF_IRQ_STAT, 32'hF);
        bus(1'b1, `SAL_OFF_IRQ_MASK, 32'h2);
        `CHK(irq_o, 1'b0)
        low_side_tap_one_high_i <= 1'b1;
        tick(2100);
        `CHK(pin, 4'hD)
        `CHK(irq_o, 1'b1)
        bus(1'b1, `SAL_OFF_IRQ_MASK, 32'h0);
        `CHK(irq_o, 1'b0)
        bus(1'b1, `SAL_OFF_IRQ_MASK, 32'h2);
        `CHK(irq_o, 1'b1)
        bus(1'b1, `SAL_OFF_IRQ_STAT, 32'h2);
        `CHK(irq_o, 1'b0)
        supply_lockout_n_i <= 1'b0;
        tick(3);
        `CHK(pin, 4'hE)
        supply_outputs_ok_i <= 1'b0;
        tick(3);
        `CHK(pin, 4'hF)
        supply_outputs_ok_i <= 1'b1;
        low_side_tap_one_high_i <= 1'b0;
        tick(3);
        supply_lockout_n_i <= 1'b1;
        tick(6);
        `CHK(pin[0], 1'b0)
        wait_pin(1, 3000);
        timeout_cap_pin_i <= SAL_PIN_VCC;
        supply_lockout_n_i <= 1'b0;
        tick(3);
        supply_lockout_n_i <= 1'b1;
        tick(6);
        `CHK(pin, 4'hF)
        upd(7'h23, 4);
        `CHK(pin, 4'hF)
        upd(7'h23, 1);
        `CHK(pin, 4'hB)
        upd(7'h1B, 4);
        `CHK(pin, 4'hB)
        upd(7'h1B, 1);
        `CHK(pin, 4'h3)
        upd(7'h18, 1);
        `CHK(pin, 4'h3)
        upd(7'h1C, 1);
        `CHK(pin, 4'h7)
        timeout_cap_pin_i <= SAL_PIN_OPEN;
        upd(7'h24, 1);
        `CHK(pin, 4'h7)
        wait_pin(3, 100);
        `CHK(n >= 10, 1'b1)
        strap <= 2'h1;
        upd(7'h63, 5);
        `CHK(pin, 4'hF)
        strap <= 2'h2;
        upd(7'h24, 5);
        `CHK(pin, 4'hB)
        strap <= 2'h3;
        upd(7'h24, 5);
        `CHK(pin, 4'h3)
        stop_test(1'b0);
    end
endmodule // sal_alert_logic_tb
`default_nettype wire
